// ==== hdl/sar_adc_conversion_control.sv ====
// Purpose: Conversion control and host interface of an 8-bit SAR converter
// Assumes: Host strobes synchronous to sys_clk_i; comparator output is sampled
// Notes:   Result bus is two signals: data, enable, no inout
//
// Functional notes
// - Unread result blocks any new conversion
// - Write mode: long select after read restarts
// - Completed read resets converter, result gone
// - Step oscillator runs while converting and for one step after a read
// - Read-started mode adds about 2 us
// - External clock gated by busy output
// - Bipolar code is offset binary
// - Unipolar code is straight binary
// - Conditioned bipolar gives complementary offset binary
// - Read end: one step, preload 10000000
// - Read rise with select low resets converter
// - Busy low while converting, high at end
`include "sar_cfg.svh"
module sar_adc_conversion_control
  import sar_pkg::*;
#(
  parameter int unsigned STEP_CYC     = `SAR_STEP_CYC,
  parameter int unsigned EXTRA_CYC    = `SAR_EXTRA_CYC,
  parameter int unsigned CS_HOLD_CYC  = 4
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire host_strobe_t host_i,
  input  wire host_mode_t   host_mode_i,
  input  wire code_mode_t   code_mode_i,
  input  wire logic         comp_above_i,
  output logic              busy_b_o,
  output logic [7:0]        trial_code_o,
  output logic [7:0]        result_bus_o,
  output logic              result_bus_oe_o,
  output logic              osc_run_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_SETTLE  = 5'b00010,
    ST_CONVERT = 5'b00100,
    ST_DONE    = 5'b01000,
    ST_RESET   = 5'b10000
  } conv_state_t;

  localparam int unsigned CNT_W = `SAR_CNT_W;

  conv_state_t      state_reg,   state_next;
  logic [7:0]       sar_reg,     sar_next;
  logic [7:0]       bit_reg,     bit_next;
  logic [7:0]       out_reg,     out_next;
  logic             oe_reg,      oe_next;
  host_strobe_t     prev_reg,    prev_next;
  logic [CNT_W-1:0] hold_reg,    hold_next;
  logic [CNT_W-1:0] extra_reg,   extra_next;
  logic             tick;
  logic             rd_rise;
  logic             cs_fall;
  logic             start;
  logic             run;

  // Output coding of a finished register value
  function automatic logic [7:0] encode(input logic [7:0] v, input code_mode_t m);
    unique case (m)
      CODE_UNIPOLAR:      encode = v;
      CODE_BIPOLAR:       encode = v;
      CODE_BIPOLAR_COMPL: encode = ~v;
      default:            encode = v;
    endcase
  endfunction : encode

  // ------------------------------------------------------------
  // Step oscillator
  // ------------------------------------------------------------
  // The step counter runs in the convert and reset states only, so every
  // conversion starts from a fresh count and the first trial bit gets a full step
  assign run       = (state_reg == ST_CONVERT) || (state_reg == ST_RESET);
  // The read-started settle span is part of the conversion, so the
  // oscillator is reported running there too, though it does not step
  assign osc_run_o = run || (state_reg == ST_SETTLE);

  sar_step_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .run_i     (run),
    .period_i  (CNT_W'(STEP_CYC)),
    .tick_o    (tick)
  );

  // ------------------------------------------------------------
  // Host strobe decode
  // ------------------------------------------------------------
  // Select is taken from the previous sample: with the strobes tied, select
  // rises together with read and the release must still reset the converter
  assign rd_rise = !prev_reg.cs_b && !prev_reg.rd_b && host_i.rd_b;
  assign cs_fall = prev_reg.cs_b && !host_i.cs_b;

  always_comb begin
    start = 1'b0;
    if (state_reg == ST_IDLE) begin
      unique case (host_mode_i)
        MODE_WRITE_START: start = (cs_fall && host_i.rd_b)
                                  || (hold_reg == CNT_W'(CS_HOLD_CYC));
        MODE_TIED:        start = cs_fall;
        MODE_READ_START:  start = 1'b0;   // Restart comes from read end
        default:          start = 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Conversion sequence
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    sar_next   = sar_reg;
    bit_next   = bit_reg;
    out_next   = out_reg;
    oe_next    = 1'b0;
    prev_next  = host_i;
    hold_next  = '0;
    extra_next = '0;
    // Select held low after a read rise while idle counts toward a restart
    if (state_reg == ST_IDLE && !host_i.cs_b && host_i.rd_b && hold_reg != '0
        && hold_reg != CNT_W'(CS_HOLD_CYC)) begin
      hold_next = hold_reg + 1'b1;
    end
    unique case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = (host_mode_i == MODE_READ_START) ? ST_SETTLE : ST_CONVERT;
          sar_next   = `SAR_PRELOAD_CODE;
          bit_next   = 8'h80;
        end
      end
      ST_SETTLE: begin
        extra_next = extra_reg + 1'b1;
        if (extra_reg + 1'b1 >= CNT_W'(EXTRA_CYC)) begin
          state_next = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (tick) begin
          if (comp_above_i) begin
            sar_next = sar_reg & ~bit_reg;
          end
          if (bit_reg[0]) begin
            state_next = ST_DONE;
          end else begin
            bit_next = bit_reg >> 1;
            sar_next = (comp_above_i ? (sar_reg & ~bit_reg) : sar_reg) | (bit_reg >> 1);
          end
        end
      end
      ST_DONE: begin
        out_next = encode(sar_reg, code_mode_i);
        oe_next  = !host_i.cs_b && !host_i.rd_b;
        if (rd_rise) begin
          state_next = ST_RESET;
        end
      end
      ST_RESET: begin
        // One oscillator step with the preload in place, then back to idle, or to settle when read-started
        sar_next = `SAR_PRELOAD_CODE;
        bit_next = 8'h80;
        if (tick) begin
          state_next = ST_IDLE;
          if (host_mode_i == MODE_READ_START) begin
            state_next = ST_SETTLE;                               // Read-started restarts
          end
          if (host_mode_i == MODE_WRITE_START && !host_i.cs_b) begin
            hold_next = CNT_W'(1);
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
      sar_reg   <= `SAR_PRELOAD_CODE;
      bit_reg   <= 8'h80;
      out_reg   <= 8'h00;
      oe_reg    <= 1'b0;
      prev_reg  <= '{cs_b: 1'b1, rd_b: 1'b1};
      hold_reg  <= '0;
      extra_reg <= '0;
    end else begin
      state_reg <= state_next;
      sar_reg   <= sar_next;
      bit_reg   <= bit_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
      prev_reg  <= prev_next;
      hold_reg  <= hold_next;
      extra_reg <= extra_next;
    end
  end

  // Busy is low in every conversion state; also gates an external clock
  assign busy_b_o        = !(state_reg == ST_SETTLE || state_reg == ST_CONVERT);
  assign trial_code_o    = sar_reg;
  assign result_bus_o    = out_reg;
  assign result_bus_oe_o = oe_reg;

endmodule : sar_adc_conversion_control

// ==== hdl/sar_cfg.svh ====
// Purpose: Timing counts and code constants for the conversion control
// Assumes: 20 MHz system clock (50 ns period)
// Notes:   Definitions only
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH

`define SAR_CLK_PERIOD_NS     50
`define SAR_MIN_CONV_NS       15000
`define SAR_EXTRA_CONV_NS     2000
// Trial-bit step: eight steps give no less than the least conversion time
`define SAR_STEP_CYC          ((`SAR_MIN_CONV_NS / 8 + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
`define SAR_EXTRA_CYC         (`SAR_EXTRA_CONV_NS / `SAR_CLK_PERIOD_NS)
`define SAR_PRELOAD_CODE      8'h80
`define SAR_CNT_W             12

`endif

// ==== hdl/sar_pkg.sv ====
// Purpose: Shared types for the conversion control
// Assumes: Nothing
// Notes:   Host strobes travel as one struct
package sar_pkg;

  typedef enum logic [1:0] {
    MODE_WRITE_START = 2'h0,
    MODE_READ_START  = 2'h1,
    MODE_TIED        = 2'h2
  } host_mode_t;

  typedef enum logic [1:0] {
    CODE_UNIPOLAR      = 2'h0,
    CODE_BIPOLAR       = 2'h1,
    CODE_BIPOLAR_COMPL = 2'h2
  } code_mode_t;

  typedef struct packed {
    logic cs_b;
    logic rd_b;
  } host_strobe_t;

endpackage : sar_pkg

// ==== hdl/sar_step_timer.sv ====
// Purpose: Conversion oscillator stand-in, a gated step tick generator
// Assumes: One clock domain
// Notes:   Counts only while run_i is high, so it is idle between conversions except for the one step after a read
`include "sar_cfg.svh"
module sar_step_timer #(
  parameter int unsigned CNT_W = `SAR_CNT_W
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             run_i,
  input  wire logic [CNT_W-1:0] period_i,
  output logic                  tick_o
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  always_comb begin
    cnt_next = '0;
    tick_o   = 1'b0;
    if (run_i) begin
      if (cnt_reg + 1'b1 >= period_i) begin
        tick_o = 1'b1;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : sar_step_timer

// ==== tb/sar_comp_model.sv ====
// Purpose: Comparator facing the trial code
// Assumes: Input level held steady per conversion
// Notes:   Settles at once, the real one is slower
module sar_comp_model (
  input  wire logic [7:0] trial_code_i,
  input  wire logic [7:0] level_i,
  output logic            comp_above_o
);
  timeunit 1ns;
  timeprecision 1ns;
  assign comp_above_o = trial_code_i > level_i;
endmodule : sar_comp_model

// ==== tb/sar_ctl_props.sv ====
// Purpose: Port checks of the conversion control
// Assumes: One clock, reset async active low
// Notes:   Pending result is rebuilt from the busy rise and the read strobes
module sar_ctl_props
  import sar_pkg::*;
#(
  parameter int unsigned STEP_CYC  = 38,
  parameter int unsigned EXTRA_CYC = 40
) (
  input wire logic         sys_clk_i,
  input wire logic         rst_b_i,
  input wire host_strobe_t host_i,
  input wire host_mode_t   host_mode_i,
  input wire code_mode_t   code_mode_i,
  input wire logic         comp_above_i,
  input wire logic         busy_b_o,
  input wire logic [7:0]   trial_code_o,
  input wire logic [7:0]   result_bus_o,
  input wire logic         result_bus_oe_o,
  input wire logic         osc_run_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic         pend_reg;
  host_strobe_t q_reg;
  logic [11:0]  low_cnt_reg;
  logic         rd_rise;
  assign rd_rise = host_i.rd_b && !q_reg.rd_b && !q_reg.cs_b;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_reg    <= 1'b0;
      q_reg       <= '{cs_b: 1'b1, rd_b: 1'b1};
      low_cnt_reg <= 12'h000;
    end else begin
      pend_reg    <= rd_rise ? 1'b0 : (pend_reg || (busy_b_o && low_cnt_reg != 12'h000));
      q_reg       <= host_i;
      low_cnt_reg <= busy_b_o ? 12'h000 : low_cnt_reg + 12'h001;
    end
  end
  busy_osc_a: assert property (!busy_b_o |-> osc_run_o) else $error("osc idle in conversion");
  done_osc_a: assert property ($rose(busy_b_o) |-> !osc_run_o) else $error("osc runs after end");
  conv_len_a: assert property ($rose(busy_b_o) |->
    low_cnt_reg >= 8 * STEP_CYC + (host_mode_i == MODE_READ_START ? EXTRA_CYC : 0)
    && low_cnt_reg <= 9 * STEP_CYC + EXTRA_CYC + 2) else $error("conversion length wrong");
  no_start_a: assert property (pend_reg |-> busy_b_o) else $error("start with unread result");
  oe_pend_a: assert property (result_bus_oe_o |-> pend_reg) else $error("bus driven with no result");
  oe_cause_a: assert property ($rose(result_bus_oe_o) |-> $past(!host_i.cs_b && !host_i.rd_b))
    else $error("bus driven without read");
  preload_a: assert property (pend_reg && rd_rise |-> ##[1:4] trial_code_o == 8'h80)
    else $error("no preload after read");
  code_a: assert property (result_bus_oe_o |-> result_bus_o ==
    (code_mode_i == CODE_BIPOLAR_COMPL ? ~trial_code_o : trial_code_o)) else $error("output code wrong");
  hold_a: assert property (busy_b_o && $past(busy_b_o) && !osc_run_o |-> $stable(trial_code_o))
    else $error("result changed while idle");
  cover property ($rose(busy_b_o));
  cover property ($rose(result_bus_oe_o));
  cover property ($rose(busy_b_o) && host_mode_i == MODE_READ_START);
endmodule : sar_ctl_props

bind sar_adc_conversion_control sar_ctl_props #(.STEP_CYC(STEP_CYC), .EXTRA_CYC(EXTRA_CYC)) u_props (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .host_i(host_i), .host_mode_i(host_mode_i),
  .code_mode_i(code_mode_i), .comp_above_i(comp_above_i), .busy_b_o(busy_b_o),
  .trial_code_o(trial_code_o), .result_bus_o(result_bus_o), .result_bus_oe_o(result_bus_oe_o),
  .osc_run_o(osc_run_o));

// ==== tb/tb.sv ====
// Purpose: Self-checking bench of the conversion control
// Assumes: Strobes change at the falling edge
// Notes:   Short step counts keep the run brief
`include "sar_cfg.svh"
module tb
  import sar_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic         sys_clk_i  = 1'b0;
  logic         rst_b_i    = 1'b0;
  host_strobe_t host       = '{cs_b: 1'b1, rd_b: 1'b1};
  host_mode_t   hmode      = MODE_WRITE_START;
  code_mode_t   cmode      = CODE_UNIPOLAR;
  logic [7:0]   level      = 8'h00;
  localparam int STEP_CYC  = 2;
  localparam int EXTRA_CYC = 2;
  logic         comp, busy_b, oe;
  logic         osc;
  logic [7:0]   trial, dbus;
  int           failures   = 0;
  int           num_checks = 0;
  int           cyc;
  always #25 sys_clk_i = ~sys_clk_i;
  sar_adc_conversion_control #(.STEP_CYC(STEP_CYC), .EXTRA_CYC(EXTRA_CYC), .CS_HOLD_CYC(4)) dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .host_i(host), .host_mode_i(hmode), .code_mode_i(cmode),
    .comp_above_i(comp), .busy_b_o(busy_b), .trial_code_o(trial), .result_bus_o(dbus),
    .result_bus_oe_o(oe), .osc_run_o(osc));
  sar_comp_model u_comp (.trial_code_i(trial), .level_i(level), .comp_above_o(comp));
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task automatic wait_busy(input logic lvl, input int lim);
    cyc = 0;
    while (busy_b !== lvl && cyc < lim) begin
      @(negedge sys_clk_i);
      cyc++;
    end
    chk({7'h00, lvl}, {7'h00, busy_b});
  endtask : wait_busy
  task automatic start_conv(input logic [7:0] lvl, input logic tied);
    level = lvl;
    @(negedge sys_clk_i);
    host = '{cs_b: 1'b0, rd_b: ~tied};
    wait_busy(1'b0, 4);
    chk(8'h01, {7'h00, osc});
    wait_busy(1'b1, 100);
    chk(8'h00, {7'h00, osc});
  endtask : start_conv
  task automatic read_out(input logic [7:0] exp, input int hold);
    @(negedge sys_clk_i);
    host = '{cs_b: 1'b0, rd_b: 1'b0};
    repeat (2) @(negedge sys_clk_i);
    chk(8'h01, {7'h00, oe});
    chk(exp, dbus);
    host.rd_b = 1'b1;
    repeat (hold) @(negedge sys_clk_i);
    host.cs_b = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk(8'h00, {7'h00, oe});
  endtask : read_out
  task automatic s_codes();
    code_mode_t m[3]  = '{CODE_UNIPOLAR, CODE_BIPOLAR, CODE_BIPOLAR_COMPL};
    logic [7:0] lv[3] = '{8'h7f, 8'h80, 8'hc3};
    for (int i = 0; i < 3; i++) begin
      cmode = m[i];
      start_conv(lv[i], 1'b0);
      chk(8'(8 * STEP_CYC), 8'(cyc));
      read_out(m[i] == CODE_BIPOLAR_COMPL ? ~lv[i] : lv[i], 1);
      chk(8'h80, trial);
    end
    cmode = CODE_UNIPOLAR;
  endtask : s_codes
  task automatic s_blocked();
    start_conv(8'h5a, 1'b0);
    host.cs_b = 1'b1;
    @(negedge sys_clk_i);
    host.cs_b = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk(8'h01, {7'h00, busy_b});
    read_out(8'h5a, 1);
  endtask : s_blocked
  task automatic s_restart();
    start_conv(8'h21, 1'b0);
    read_out(8'h21, 8);
    chk(8'h00, {7'h00, busy_b});
    wait_busy(1'b1, 100);
    read_out(8'h21, 1);
  endtask : s_restart
  task automatic s_tied();
    hmode = MODE_TIED;
    start_conv(8'h3c, 1'b1);
    repeat (2) @(negedge sys_clk_i);
    chk(8'h3c, dbus);
    host = '{cs_b: 1'b1, rd_b: 1'b1};
    repeat (3) @(negedge sys_clk_i);
    chk(8'h00, {7'h00, oe});
    hmode = MODE_WRITE_START;
  endtask : s_tied
  task automatic s_read_mode();
    start_conv(8'h99, 1'b0);
    @(negedge sys_clk_i);
    hmode = MODE_READ_START;
    level = 8'h44;
    read_out(8'h99, 1);
    chk(8'h80, trial);
    wait_busy(1'b1, 100);
    chk(8'(8 * STEP_CYC + EXTRA_CYC), 8'(cyc));
    read_out(8'h44, 1);
  endtask : s_read_mode
  task automatic wrap_up();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (10) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    @(negedge sys_clk_i);
    host = '{cs_b: 1'b0, rd_b: 1'b0};
    repeat (3) @(negedge sys_clk_i);
    chk(8'h00, {7'h00, oe});
    chk(8'h01, {7'h00, 8 * `SAR_STEP_CYC * `SAR_CLK_PERIOD_NS >= `SAR_MIN_CONV_NS});
    host = '{cs_b: 1'b1, rd_b: 1'b1};
    s_codes();
    s_blocked();
    s_restart();
    s_tied();
    s_read_mode();
    wrap_up();
  end
  initial begin
    #(50 * 3000);
    failures++;
    wrap_up();
  end
endmodule : tb
